// >>> rtl/pit_defines.svh
// offsets, control word fields and reset values of the interval timer bus interface
`ifndef PIT_DEFINES_SVH
`define PIT_DEFINES_SVH
`define PIT_PORT_CNT0 2'h0
`define PIT_PORT_CNT1 2'h1
`define PIT_PORT_CNT2 2'h2
`define PIT_PORT_CTRL 2'h3
`define PIT_CW_SC_HI 7
`define PIT_CW_SC_LO 6
`define PIT_CW_RW_HI 5
`define PIT_CW_RW_LO 4
`define PIT_CW_M_HI 3
`define PIT_CW_M_LO 1
`define PIT_CW_BCD 0
`define PIT_SC_READBACK 2'h3
`define PIT_RW_LATCH 2'h0
`define PIT_RW_LSB 2'h1
`define PIT_RW_MSB 2'h2
`define PIT_RW_BOTH 2'h3
`define PIT_RB_NCOUNT 5
`define PIT_RB_NSTATUS 4
`define PIT_RST_BYTE 8'h00
`define PIT_RST_WORD 16'h0000
`endif

// >>> rtl/pit_pkg.sv
// types shared by the interval timer bus interface
package pit_pkg;
   typedef enum logic [1:0] {
      PIT_ACC_LATCH = 2'b00,
      PIT_ACC_LSB = 2'b01,
      PIT_ACC_MSB = 2'b10,
      PIT_ACC_BOTH = 2'b11
   } pit_access_t;
   typedef logic [7:0] pit_byte_t;
   typedef logic [15:0] pit_count_t;
endpackage : pit_pkg

// >>> rtl/pit_counter.sv
// one 16-bit down counter with count register, output latch and status
`timescale 1ns/1ps
`default_nettype none
`include "pit_defines.svh"
module pit_counter (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // host side, already decoded
   input wire logic prog_stb,
   input wire logic [5:0] prog_cw,
   input wire logic latch_stb,
   input wire logic status_stb,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire pit_pkg::pit_byte_t wr_data,
   output var pit_pkg::pit_byte_t rd_data,
   // counter pins, already synchronised
   input wire logic cnt_clk,
   input wire logic cnt_gate,
   output logic cnt_out
);
   import pit_pkg::*;

   logic [5:0] cw_q, cw_d;
   pit_count_t cr_q, cr_d, ce_q, ce_d, ol_q, ol_d;
   pit_byte_t st_q, st_d;
   logic ol_held_q, ol_held_d, st_held_q, st_held_d;
   logic wr_hi_q, wr_hi_d, rd_hi_q, rd_hi_d;
   logic load_q, load_d, null_q, null_d, out_q, out_d, clk_q;
   logic tick;
   pit_access_t acc;

   function automatic pit_count_t dec_count(input pit_count_t v, input logic bcd);
      pit_count_t r;
      integer i;
      logic borrow;
      r = v;
      if (!bcd) begin
         r = v - 16'h0001;
      end else begin
         borrow = 1'b1;
         for (i = 0; i < 4; i++) begin
            if (borrow) begin
               if (v[i*4 +: 4] == 4'h0) begin
                  r[i*4 +: 4] = 4'h9;
               end else begin
                  r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
                  borrow = 1'b0;
               end
            end
         end
      end
      return r;
   endfunction : dec_count

   assign acc = pit_access_t'(cw_q[5:4]);
   assign tick = cnt_clk & ~clk_q & cnt_gate;
   assign cnt_out = out_q;

   always_comb begin
      cw_d = cw_q;
      cr_d = cr_q;
      ce_d = ce_q;
      ol_d = ol_q;
      st_d = st_q;
      ol_held_d = ol_held_q;
      st_held_d = st_held_q;
      wr_hi_d = wr_hi_q;
      rd_hi_d = rd_hi_q;
      load_d = 1'b0;
      null_d = null_q;
      out_d = out_q;
      if (prog_stb) begin
         // programming clears both count register bytes
         cw_d = prog_cw;
         cr_d = `PIT_RST_WORD;
         wr_hi_d = 1'b0;
         rd_hi_d = 1'b0;
         ol_held_d = 1'b0;
         null_d = 1'b1;
         out_d = 1'b0;
      end else if (wr_stb) begin
         // one byte at a time into the count register
         unique case (acc)
            PIT_ACC_LSB: begin
               cr_d[7:0] = wr_data;
               load_d = 1'b1;
            end
            PIT_ACC_MSB: begin
               cr_d[15:8] = wr_data;
               load_d = 1'b1;
            end
            PIT_ACC_BOTH: begin
               if (wr_hi_q) begin
                  cr_d[15:8] = wr_data;
                  load_d = 1'b1;
               end else begin
                  cr_d[7:0] = wr_data;
               end
               wr_hi_d = ~wr_hi_q;
            end
            PIT_ACC_LATCH: begin
            end
         endcase
      end
      if (load_q) begin
         ce_d = cr_q;
         null_d = 1'b0;
      end else if (tick) begin
         ce_d = dec_count(ce_q, cw_q[`PIT_CW_BCD]);
         if (ce_q == 16'h0001) begin
            out_d = 1'b1;
         end
      end
      // read completion first; a latch in the same cycle is ignored if a latch was already held
      if (rd_stb) begin
         if (st_held_q) begin
            st_held_d = 1'b0;
         end else if (acc == PIT_ACC_BOTH && !rd_hi_q) begin
            rd_hi_d = 1'b1;
         end else begin
            rd_hi_d = 1'b0;
            ol_held_d = 1'b0;
         end
      end
      if (latch_stb && !ol_held_q) begin
         ol_held_d = 1'b1;
      end
      if (!ol_held_d) begin
         ol_d = ce_d;
      end
      if (status_stb && !st_held_q) begin
         st_d = {out_q, null_q, cw_q};
         st_held_d = 1'b1;
      end
   end

   // status or output latch, never the counting element
   always_comb begin
      if (st_held_q) begin
         rd_data = st_q;
      end else if (acc == PIT_ACC_MSB || (acc == PIT_ACC_BOTH && rd_hi_q)) begin
         rd_data = ol_q[15:8];
      end else begin
         rd_data = ol_q[7:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cw_q <= 6'h00;
         cr_q <= `PIT_RST_WORD;
         ce_q <= `PIT_RST_WORD;
         ol_q <= `PIT_RST_WORD;
         st_q <= `PIT_RST_BYTE;
         ol_held_q <= 1'b0;
         st_held_q <= 1'b0;
         wr_hi_q <= 1'b0;
         rd_hi_q <= 1'b0;
         load_q <= 1'b0;
         null_q <= 1'b0;
         out_q <= 1'b0;
         clk_q <= 1'b0;
      end else begin
         cw_q <= cw_d;
         cr_q <= cr_d;
         ce_q <= ce_d;
         ol_q <= ol_d;
         st_q <= st_d;
         ol_held_q <= ol_held_d;
         st_held_q <= st_held_d;
         wr_hi_q <= wr_hi_d;
         rd_hi_q <= rd_hi_d;
         load_q <= load_d;
         null_q <= null_d;
         out_q <= out_d;
         clk_q <= cnt_clk;
      end
   end
endmodule : pit_counter
`default_nettype wire

// >>> rtl/pit_top.sv
// bus interface and read/write logic of the three-channel interval timer
// What this block does
// - port select 00,01,10 counters; 11 control word
// - strobes ignored unless chip select low
// - read low drives addressed counter byte out
// - write low transfers control word or count
// - port 11 write stores and executes control word
// - control word write-only; status via read-back
// - 8-bit data bus undriven unless reading
// - three independent 16-bit counters
// - each counter own clock, gate, output
// - binary or BCD counting per counter
// - target counter taken from control word field
// - reads return output latch, byte-wise
// - count bytes staged, loaded together
`timescale 1ns/1ps
`default_nettype none
`include "pit_defines.svh"
module pit_top (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST_N,
   // host bus
   input wire logic CS_N,
   input wire logic RD_N,
   input wire logic WR_N,
   input wire logic [1:0] PORT_SELECT,
   input wire pit_pkg::pit_byte_t HOST_BUS_LINES_I,
   output var pit_pkg::pit_byte_t HOST_BUS_LINES_O,
   output logic HOST_BUS_LINES_OE,
   // counter pins
   input wire logic [2:0] CNT_CLK,
   input wire logic [2:0] CNT_GATE,
   output logic [2:0] CNT_OUT
);
   import pit_pkg::*;

   logic rst_s1_q, rst_n_s;
   logic [1:0] cs_n_s, rd_n_s, wr_n_s;
   logic [1:0] ps_s [2];
   pit_byte_t di_s [2];
   logic [2:0] ck_s [2];
   logic [2:0] gt_s [2];
   logic rd_act, wr_act, wr_prev_q, rd_prev_q, wr_stb, rd_end;
   logic [2:0] prog_stb, latch_stb, status_stb, cnt_wr, cnt_rd;
   pit_byte_t cnt_rdata [3];
   pit_byte_t dout_q, dout_d;
   logic oe_q, oe_d;
   pit_byte_t cw;

   ////////////////////////////////////////////////////////////////////////
   // reset release and pin synchronisers
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         rst_s1_q <= 1'b0;
         rst_n_s <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_s <= rst_s1_q;
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_n_s) begin
      if (!rst_n_s) begin
         cs_n_s <= 2'h3;
         rd_n_s <= 2'h3;
         wr_n_s <= 2'h3;
         ps_s[0] <= 2'h0;
         ps_s[1] <= 2'h0;
         di_s[0] <= `PIT_RST_BYTE;
         di_s[1] <= `PIT_RST_BYTE;
         ck_s[0] <= 3'h0;
         ck_s[1] <= 3'h0;
         gt_s[0] <= 3'h0;
         gt_s[1] <= 3'h0;
      end else begin
         cs_n_s <= {cs_n_s[0], CS_N};
         rd_n_s <= {rd_n_s[0], RD_N};
         wr_n_s <= {wr_n_s[0], WR_N};
         ps_s[1] <= ps_s[0];
         ps_s[0] <= PORT_SELECT;
         di_s[1] <= di_s[0];
         di_s[0] <= HOST_BUS_LINES_I;
         ck_s[1] <= ck_s[0];
         ck_s[0] <= CNT_CLK;
         gt_s[1] <= gt_s[0];
         gt_s[0] <= CNT_GATE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // strobe qualification and decode
   assign rd_act = ~cs_n_s[1] & ~rd_n_s[1];
   assign wr_act = ~cs_n_s[1] & ~wr_n_s[1];
   // write taken at the trailing edge so the data has settled
   assign wr_stb = wr_prev_q & ~wr_act;
   assign rd_end = rd_prev_q & ~rd_act;
   assign cw = di_s[1];

   always_comb begin
      prog_stb = 3'h0;
      latch_stb = 3'h0;
      status_stb = 3'h0;
      cnt_wr = 3'h0;
      cnt_rd = 3'h0;
      if (wr_stb) begin
         if (ps_s[1] == `PIT_PORT_CTRL) begin
            if (cw[`PIT_CW_SC_HI:`PIT_CW_SC_LO] == `PIT_SC_READBACK) begin
               latch_stb = cw[`PIT_RB_NCOUNT] ? 3'h0 : cw[3:1];
               status_stb = cw[`PIT_RB_NSTATUS] ? 3'h0 : cw[3:1];
            end else if (cw[`PIT_CW_RW_HI:`PIT_CW_RW_LO] == `PIT_RW_LATCH) begin
               latch_stb[cw[`PIT_CW_SC_HI:`PIT_CW_SC_LO]] = 1'b1;
            end else begin
               prog_stb[cw[`PIT_CW_SC_HI:`PIT_CW_SC_LO]] = 1'b1;
            end
         end else begin
            cnt_wr[ps_s[1]] = 1'b1;
         end
      end
      if (rd_end && ps_s[1] != `PIT_PORT_CTRL) begin
         cnt_rd[ps_s[1]] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data path, registered
   always_comb begin
      dout_d = dout_q;
      oe_d = 1'b0;
      if (rd_act && ps_s[1] != `PIT_PORT_CTRL) begin
         oe_d = 1'b1;
         dout_d = cnt_rdata[ps_s[1]];
      end
      // control word port never drives the bus
      if (ps_s[1] == `PIT_PORT_CTRL) begin
         oe_d = 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_n_s) begin
      if (!rst_n_s) begin
         dout_q <= `PIT_RST_BYTE;
         oe_q <= 1'b0;
         wr_prev_q <= 1'b0;
         rd_prev_q <= 1'b0;
      end else begin
         dout_q <= dout_d;
         oe_q <= oe_d;
         wr_prev_q <= wr_act;
         rd_prev_q <= rd_act;
      end
   end

   assign HOST_BUS_LINES_O = dout_q;
   assign HOST_BUS_LINES_OE = oe_q;

   ////////////////////////////////////////////////////////////////////////
   // the three counters
   for (genvar g = 0; g < 3; g++) begin : g_cnt
      pit_counter u_cnt (
         .clk(CLK_SYS),
         .rst_n(rst_n_s),
         .prog_stb(prog_stb[g]),
         .prog_cw(cw[5:0]),
         .latch_stb(latch_stb[g]),
         .status_stb(status_stb[g]),
         .wr_stb(cnt_wr[g]),
         .rd_stb(cnt_rd[g]),
         .wr_data(cw),
         .rd_data(cnt_rdata[g]),
         .cnt_clk(ck_s[1][g]),
         .cnt_gate(gt_s[1][g]),
         .cnt_out(CNT_OUT[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_oe_ctrl;
      @(posedge CLK_SYS) disable iff (!rst_n_s)
         (ps_s[1] == `PIT_PORT_CTRL) |=> !HOST_BUS_LINES_OE;
   endproperty
   a_oe_ctrl: assert property (p_oe_ctrl) else $error("bus driven on control port");

   property p_no_cs;
      @(posedge CLK_SYS) disable iff (!rst_n_s)
         cs_n_s[1] |=> !HOST_BUS_LINES_OE;
   endproperty
   a_no_cs: assert property (p_no_cs) else $error("bus driven while deselected");

   property p_rd_drive;
      @(posedge CLK_SYS) disable iff (!rst_n_s)
         (rd_act && ps_s[1] != `PIT_PORT_CTRL) |=> HOST_BUS_LINES_OE;
   endproperty
   a_rd_drive: assert property (p_rd_drive) else $error("read not answered");

   property p_idle_float;
      @(posedge CLK_SYS) disable iff (!rst_n_s)
         !rd_act |=> !HOST_BUS_LINES_OE;
   endproperty
   a_idle_float: assert property (p_idle_float) else $error("bus driven without read");

   property p_rd_data;
      @(posedge CLK_SYS) disable iff (!rst_n_s)
         (rd_act && ps_s[1] == 2'h1) |=> HOST_BUS_LINES_O == $past(cnt_rdata[1]);
   endproperty
   a_rd_data: assert property (p_rd_data) else $error("wrong counter read");

   property p_cw_target;
      @(posedge CLK_SYS) disable iff (!rst_n_s)
         (wr_stb && ps_s[1] == `PIT_PORT_CTRL && cw[7:6] == 2'h2 && cw[5:4] != 2'h0) |-> prog_stb == 3'h4;
   endproperty
   a_cw_target: assert property (p_cw_target) else $error("control word target wrong");

   property p_cnt_wr;
      @(posedge CLK_SYS) disable iff (!rst_n_s)
         (wr_stb && ps_s[1] == 2'h0) |-> (cnt_wr == 3'h1 && prog_stb == 3'h0);
   endproperty
   a_cnt_wr: assert property (p_cnt_wr) else $error("count write misrouted");

   property p_no_wr_deselect;
      @(posedge CLK_SYS) disable iff (!rst_n_s)
         cs_n_s[1] |=> (cnt_wr == 3'h0 && prog_stb == 3'h0 && latch_stb == 3'h0);
   endproperty
   a_no_wr_deselect: assert property (p_no_wr_deselect) else $error("write taken while deselected");
endmodule : pit_top
`default_nettype wire

// >>> dv/pit_host_model.sv
// host cpu model driving the timer's parallel bus
`timescale 1ns/1ps
`default_nettype none
module pit_host_model (
   // clock
   input wire logic clk,
   // strobes and select
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic [1:0] port_select,
   // data lines
   output pit_pkg::pit_byte_t bus_i,
   input wire pit_pkg::pit_byte_t bus_o,
   input wire logic bus_oe
);
   import pit_pkg::*;
   pit_byte_t wdata_q;
   pit_byte_t last_q;
   logic drv_q;
   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      port_select = 2'h3;
      wdata_q = 8'h00;
      last_q = 8'h00;
      drv_q = 1'b0;
   end
   // released lines toggle so no stale value reads as valid
   assign bus_i = bus_oe ? bus_o : (drv_q ? wdata_q : ~last_q);
   always @(posedge clk) begin
      last_q <= bus_i;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic wr_cycle(input logic [1:0] p, input pit_byte_t d, input logic cs);
      @(posedge clk);
      port_select <= p;
      wdata_q <= d;
      drv_q <= 1'b1;
      cs_n <= ~cs;
      @(posedge clk);
      wr_n <= 1'b0;
      repeat (4) @(posedge clk);
      wr_n <= 1'b1;
      // select and data held past the trailing edge
      repeat (4) @(posedge clk);
      cs_n <= 1'b1;
      drv_q <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : wr_cycle
   task automatic rd_cycle(input logic [1:0] p, input logic cs, input logic drive, output logic ok);
      int n;
      ok = 1'b1;
      @(posedge clk);
      port_select <= p;
      cs_n <= ~cs;
      @(posedge clk);
      rd_n <= 1'b0;
      n = 0;
      while (drive && bus_oe !== 1'b1 && n < 12) begin
         @(posedge clk);
         n++;
      end
      if (drive && bus_oe !== 1'b1) begin
         ok = 1'b0;
      end
      repeat (drive ? 2 : 8) @(posedge clk);
      rd_n <= 1'b1;
      repeat (5) @(posedge clk);
      cs_n <= 1'b1;
      repeat (2) @(posedge clk);
   endtask : rd_cycle
endmodule : pit_host_model
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench of the interval timer bus interface
`timescale 1ns/1ps
`default_nettype none
module tb;
   import pit_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic cs_n;
   logic rd_n;
   logic wr_n;
   logic [1:0] port_select;
   pit_byte_t bus_i;
   pit_byte_t bus_o;
   logic bus_oe;
   logic [2:0] cnt_clk = 3'h0;
   logic [2:0] cnt_gate = 3'h0;
   logic [2:0] cnt_out;
   pit_byte_t exp_q[$];
   int err_total = 0;
   int checked = 0;
   logic [31:0] lfsr = 32'h8303;
   pit_byte_t rnd;
   logic oe_prev = 1'b0;
   always #10 clk_sys = ~clk_sys;
   pit_top pit_top_inst (.CLK_SYS(clk_sys), .RST_N(rst_n), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n),
      .PORT_SELECT(port_select), .HOST_BUS_LINES_I(bus_i), .HOST_BUS_LINES_O(bus_o),
      .HOST_BUS_LINES_OE(bus_oe), .CNT_CLK(cnt_clk), .CNT_GATE(cnt_gate), .CNT_OUT(cnt_out));
   pit_host_model pit_host_model_inst (.clk(clk_sys), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
      .port_select(port_select), .bus_i(bus_i), .bus_o(bus_o), .bus_oe(bus_oe));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr_next
   task automatic chk8(input pit_byte_t got, input pit_byte_t exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: read %h, want %h", $time, got, exp);
      end
   endtask : chk8
   task automatic chk3(input logic [2:0] got, input logic [2:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: outputs %b, want %b", $time, got, exp);
      end
   endtask : chk3
   task automatic conclude;
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude
   task automatic wr(input logic [1:0] p, input pit_byte_t d, input logic cs);
      pit_host_model_inst.wr_cycle(p, d, cs);
   endtask : wr
   task automatic rd(input logic [1:0] p, input logic cs, input logic drive, input pit_byte_t e);
      logic ok;
      if (drive) begin
         exp_q.push_back(e);
      end
      pit_host_model_inst.rd_cycle(p, cs, drive, ok);
      if (ok !== 1'b1) begin
         err_total++;
         $display("CHECK FAILED at %0t: no read data", $time);
         conclude();
      end
   endtask : rd
   task automatic pulse(input int idx, input int n);
      repeat (n) begin
         cnt_clk[idx] <= 1'b1;
         repeat (4) @(posedge clk_sys);
         cnt_clk[idx] <= 1'b0;
         repeat (4) @(posedge clk_sys);
      end
   endtask : pulse
   ////////////////////////////////////////////////////////////////////////
   // result watcher: one note per rising bus drive
   always @(posedge clk_sys) begin
      oe_prev <= bus_oe;
      if (bus_oe === 1'b1 && oe_prev !== 1'b1) begin
         if (exp_q.size() == 0) begin
            err_total++;
            $display("CHECK FAILED at %0t: bus driven unasked", $time);
         end else begin
            chk8(bus_o, exp_q.pop_front());
         end
      end
   end
   initial begin
      repeat (50000) @(posedge clk_sys);
      err_total++;
      $display("CHECK FAILED at %0t: run too long", $time);
      conclude();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk3(cnt_out, 3'h0);
      // counter 0 in bcd, both bytes, then latched
      wr(2'h3, 8'h31, 1'b1);
      wr(2'h0, 8'h00, 1'b1);
      wr(2'h0, 8'h10, 1'b1);
      rd(2'h0, 1'b1, 1'b1, 8'h00);
      rd(2'h0, 1'b1, 1'b1, 8'h10);
      wr(2'h3, 8'h00, 1'b1);
      cnt_gate[0] <= 1'b1;
      @(posedge clk_sys);
      pulse(0, 1);
      cnt_gate[0] <= 1'b0;
      rd(2'h0, 1'b1, 1'b1, 8'h00);
      rd(2'h0, 1'b1, 1'b1, 8'h10);
      rd(2'h0, 1'b1, 1'b1, 8'h99);
      rd(2'h0, 1'b1, 1'b1, 8'h09);
      // counter 1 runs out alone
      wr(2'h3, 8'h50, 1'b1);
      wr(2'h1, 8'h02, 1'b1);
      chk3(cnt_out, 3'h0);
      cnt_gate[1] <= 1'b1;
      @(posedge clk_sys);
      pulse(1, 3);
      chk3(cnt_out, 3'h2);
      // read-back of counter 1: status first, then the latched count
      wr(2'h3, 8'hc4, 1'b1);
      rd(2'h1, 1'b1, 1'b1, 8'h90);
      rd(2'h1, 1'b1, 1'b1, 8'hff);
      // counter 2, high byte only, random counts
      wr(2'h3, 8'ha0, 1'b1);
      for (int i = 0; i < 3; i++) begin
         lfsr = lfsr_next(lfsr);
         rnd = lfsr[7:0];
         wr(2'h2, rnd, 1'b1);
         rd(2'h2, 1'b1, 1'b1, rnd);
      end
      wr(2'h2, ~rnd, 1'b0);
      wr(2'h3, 8'h10, 1'b0);
      rd(2'h2, 1'b1, 1'b1, rnd);
      // counter 0 must still be in two-byte mode
      rd(2'h0, 1'b1, 1'b1, 8'h99);
      rd(2'h0, 1'b1, 1'b1, 8'h09);
      rd(2'h2, 1'b0, 1'b0, 8'h00);
      rd(2'h3, 1'b1, 1'b0, 8'h00);
      rd(2'h2, 1'b1, 1'b1, rnd);
      chk3(cnt_out, 3'h2);
      checked++;
      if (exp_q.size() != 0) begin
         err_total++;
         $display("CHECK FAILED at %0t: reads left unanswered", $time);
      end
      conclude();
   end
endmodule : tb
`default_nettype wire
